/* File: rtl/sapm_aggr_ctl.sv */
// Aggregate protection, laser shutoff, performance and cross-connect control
// Overview of operation
// RULE1 - One-plus-one protection, working and standby fibers
// RULE2 - Fault on working line switches within 30 ms
// RULE3 - Non-revertive mode stays on switched line
// RULE4 - Revertive mode returns to primary after recovery
// RULE5 - Reset: non-revertive, zero wait, 3e-5
// RULE6 - Normal manual switch needs healthy protection line
// RULE7 - Lock manual switch is unconditional
// RULE8 - Optical failure sends AIS on tributaries
// RULE9 - Laser shutoff when remote signal lost
// RULE10 - Periodic laser restart, 60 to 300 s
// RULE11 - Recovery or manual command restores laser
// RULE12 - Laser shutoff selectable, disabled by default
// RULE13 - Count four parameters, four layers, both ends
// RULE14 - Quarter, hour, day intervals with history
// RULE15 - Settable thresholds raise crossing alarms
// RULE16 - Optical line code violation defaults
// RULE17 - Optical path code violation defaults
// RULE18 - E1 line code violation defaults
// RULE19 - E1 path code violation defaults
// RULE20 - Errored, severe, unavailable second defaults
// RULE21 - Channel number maps to K, L, M
// RULE22 - Add and drop through assigned channel
// RULE23 - Wait-to-restore restarts on new fault
`timescale 1ns/1ps
module sapm_aggr_ctl #(
    parameter logic [31:0] SEC_CYC = sapm_pkg::SEC_CYC_DEF
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire sapm_pkg::sapm_line_t [1:0] LINE_I,
    input wire logic CFG_WE_I,
    input wire sapm_pkg::sapm_cfg_t CFG_I,
    input wire logic MAN_REQ_I,
    input wire logic MAN_LOCK_I,
    input wire logic LASER_START_I,
    input wire logic [31:0] PM_EVT_I,
    input wire logic THR_WE_I,
    input wire logic [4:0] THR_PAR_I,
    input wire logic [1:0] THR_IV_I,
    input wire logic [31:0] THR_VAL_I,
    input wire logic [4:0] PM_RD_PAR_I,
    input wire logic [1:0] PM_RD_IV_I,
    input wire logic [6:0] PM_RD_IDX_I,
    input wire logic MAP_WE_I,
    input wire logic [5:0] MAP_PORT_I,
    input wire logic [5:0] MAP_CHAN_I,
    input wire sapm_pkg::sapm_trib_t ADD_I,
    input wire sapm_pkg::sapm_agg_t DROP_I,
    output sapm_pkg::sapm_cfg_t CFG_O,
    output logic SEL_LINE_O,
    output sapm_pkg::sapm_prot_st_t PROT_ST_O,
    output logic LOCK_O,
    output logic MAN_REJ_O,
    output logic LINE_FAIL_O,
    output logic LASER_ON_O,
    output logic [95:0] TCA_O,
    output logic [31:0] PM_RD_DATA_O,
    output sapm_pkg::sapm_agg_t ADD_O,
    output sapm_pkg::sapm_trib_t DROP_O
);
    import sapm_pkg::*;
    typedef struct packed {
        sapm_prot_st_t st;
        logic sel;
        logic lock;
        logic rej;
        logic fail;
        logic [9:0] wait_to_restore;
        logic [SEC_W-1:0] sec;
        logic tick;
        logic [9:0] s15;
        logic [1:0] q;
        logic [4:0] h;
        logic [2:0] ends;
        sapm_cfg_t cfg;
        logic [62:0][5:0] map;
        sapm_agg_t add;
        sapm_trib_t drop;
        logic [31:0] rd;
        logic [95:0] threshold_crossing_alarm;
    } sapm_top_state_t;
    localparam sapm_top_state_t RST = '{st: PS_WORK, cfg: CFG_DEF, default: '0};
    sapm_top_state_t s_q, s_d;
    logic [1:0] fail;
    logic act_fail;
    logic oth_fail;
    logic [9:0] wtr_lim;
    logic [95:0] tca_w;
    logic [N_PAR-1:0][31:0] rd_w;

    // Line health seen on the selected and the standby fiber
    assign fail[0] = |LINE_I[0];
    assign fail[1] = |LINE_I[1];
    assign act_fail = fail[s_q.sel]; // RULE1
    assign oth_fail = fail[~s_q.sel];
    // Widen before the product so 15 min (900 s) does not wrap
    assign wtr_lim = 10'(s_q.cfg.wtr_min) * 10'(SEC_PER_MIN);

    // Protection, timing, configuration and cross-connect
    always_comb
    begin
        logic [5:0] ch;
        ch = '0;
        s_d = s_q;
        s_d.rej = 1'b0;
        s_d.fail = act_fail;
        // Second tick and interval boundaries
        s_d.tick = 1'b0;
        s_d.ends = '0;
        if (s_q.sec >= SEC_W'(SEC_CYC - 32'h0000_0001))
        begin
            s_d.sec = '0;
            s_d.tick = 1'b1;
        end
        else
            s_d.sec = s_q.sec + SEC_W'(1);
        if (s_q.tick)
        begin
            s_d.s15 = s_q.s15 + 10'h001;
            if (s_q.s15 == Q15_LAST)
            begin
                s_d.s15 = '0;
                s_d.ends[0] = 1'b1; // RULE14
                s_d.q = s_q.q + 2'h1;
                if (s_q.q == Q_LAST)
                begin
                    s_d.ends[1] = 1'b1;
                    s_d.h = (s_q.h == H_LAST) ? 5'h00 : s_q.h + 5'h01;
                    s_d.ends[2] = (s_q.h == H_LAST);
                end
            end
        end
        // Configuration write, restart delay held in range
        if (CFG_WE_I)
        begin
            s_d.cfg = CFG_I;
            if (CFG_I.delay_sec < DLY_MIN)
                s_d.cfg.delay_sec = DLY_MIN; // RULE10
            else if (CFG_I.delay_sec > DLY_MAX)
                s_d.cfg.delay_sec = DLY_MAX;
        end
        // Manual command beats automatic action
        if (MAN_REQ_I)
        begin
            if (MAN_LOCK_I || !oth_fail) // RULE6 RULE7
            begin
                s_d.sel = ~s_q.sel;
                s_d.lock = MAN_LOCK_I;
                s_d.st = s_q.sel ? PS_WORK : PS_PROT;
                s_d.wait_to_restore = '0;
            end
            else
                s_d.rej = 1'b1; // RULE6
        end
        else if (!s_q.lock && act_fail && !oth_fail)
        begin
            s_d.sel = ~s_q.sel; // RULE2
            s_d.st = s_q.sel ? PS_WORK : PS_PROT;
            s_d.wait_to_restore = '0;
        end
        else if (!s_q.lock && s_q.sel && s_q.cfg.revert)
        begin
            // Wait on the standby until the primary stays clean
            if (fail[0])
            begin
                s_d.st = PS_PROT; // RULE23
                s_d.wait_to_restore = '0;
            end
            else if (s_q.st == PS_PROT)
                s_d.st = PS_WTR;
            else if (s_q.wait_to_restore >= wtr_lim || (s_q.tick && s_q.wait_to_restore + 10'h001 >= wtr_lim))
            begin
                s_d.sel = 1'b0; // RULE4
                s_d.st = PS_WORK;
                s_d.wait_to_restore = '0;
            end
            else if (s_q.tick)
                s_d.wait_to_restore = s_q.wait_to_restore + 10'h001; // RULE23
        end
        else if (s_q.st == PS_WTR)
            s_d.st = PS_PROT; // RULE3
        // Channel assignment table
        if (MAP_WE_I && MAP_PORT_I < N_CHAN)
            s_d.map[MAP_PORT_I] = (MAP_CHAN_I > N_CHAN) ? 6'h00 : MAP_CHAN_I;
        // Add direction: port to its channel position
        s_d.add = '0;
        if (ADD_I.valid && ADD_I.port < N_CHAN && s_q.map[ADD_I.port] != 6'h00)
        begin
            s_d.add.valid = 1'b1; // RULE22
            s_d.add.pos = sapm_ch2pos(s_q.map[ADD_I.port]); // RULE21
            s_d.add.data = ADD_I.data;
        end
        // Drop direction: position back to its port
        s_d.drop = '0;
        if (DROP_I.valid)
        begin
            ch = sapm_pos2ch(DROP_I.pos); // RULE21
            for (int p = 0; p < 63; p++)
            begin
                if (s_q.map[p] == ch && ch != 6'h00)
                begin
                    s_d.drop.valid = 1'b1; // RULE22
                    s_d.drop.port = 6'(p);
                end
            end
            s_d.drop.data = act_fail ? AIS_BYTE : DROP_I.data; // RULE8
        end
        s_d.threshold_crossing_alarm = tca_w;
        s_d.rd = rd_w[PM_RD_PAR_I];
    end

    // State register
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
            s_q <= RST; // RULE5 RULE12
        else
            s_q <= s_d;
    end

    // Laser shutoff on loss of the received optical signal
    sapm_laser u_laser (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .sec_tick_i(s_q.tick),
        .als_en_i(s_q.cfg.als_en), // RULE12
        .rx_fail_i(LINE_I[s_q.sel].los | LINE_I[s_q.sel].lof), // RULE9
        .delay_sec_i(s_q.cfg.delay_sec),
        .man_start_i(LASER_START_I), // RULE11
        .laser_on_o(LASER_ON_O)
    );

    // One counter per layer, end and parameter with its defaults
    for (genvar g = 0; g < N_PAR; g++)
    begin : g_pm
        sapm_pm #(
            .DEF15(sapm_thr_def(g, 0)), // RULE16 RULE17 RULE18 RULE19 RULE20
            .DEF1H(sapm_thr_def(g, 1)),
            .DEF1D(sapm_thr_def(g, 2))
        ) u_pm (
            .clk_i(CLK_I),
            .rstn_i(RSTN_I),
            .inc_i(PM_EVT_I[g]), // RULE13
            .end_i(s_q.ends),
            .thr_we_i(THR_WE_I && THR_PAR_I == 5'(g)), // RULE15
            .thr_iv_i(THR_IV_I),
            .thr_val_i(THR_VAL_I),
            .rd_iv_i(PM_RD_IV_I),
            .rd_idx_i(PM_RD_IDX_I),
            .tca_o(tca_w[3*g +: 3]),
            .rd_data_o(rd_w[g])
        );
    end

    // Outputs from the state register
    assign CFG_O = s_q.cfg;
    assign SEL_LINE_O = s_q.sel;
    assign PROT_ST_O = s_q.st;
    assign LOCK_O = s_q.lock;
    assign MAN_REJ_O = s_q.rej;
    assign LINE_FAIL_O = s_q.fail;
    assign TCA_O = s_q.threshold_crossing_alarm;
    assign PM_RD_DATA_O = s_q.rd;
    assign ADD_O = s_q.add;
    assign DROP_O = s_q.drop;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    chk_auto_switch: assert property (!MAN_REQ_I && !s_q.lock && act_fail && !oth_fail
        |=> SEL_LINE_O != $past(s_q.sel)) // RULE2
        else $error("no switch away from failed line");
    chk_nonrev_hold: assert property (!s_q.cfg.revert && !MAN_REQ_I && !(act_fail && !oth_fail)
        |=> $stable(SEL_LINE_O)) // RULE3
        else $error("non-revertive line changed");
    chk_wtr_restart: assert property (s_q.st == PS_WTR && fail[0] && !MAN_REQ_I && !act_fail
        |=> PROT_ST_O == PS_PROT && SEL_LINE_O) // RULE23
        else $error("wait not restarted on new fault");
    chk_rev_return: assert property (s_q.st == PS_WTR && s_q.cfg.revert && !s_q.lock && !MAN_REQ_I
        && !fail[0] && (s_q.wait_to_restore >= wtr_lim || (s_q.tick && s_q.wait_to_restore + 10'h001 >= wtr_lim))
        |=> !SEL_LINE_O && PROT_ST_O == PS_WORK) // RULE4
        else $error("revertive return to primary missing");
    chk_man_refuse: assert property (MAN_REQ_I && !MAN_LOCK_I && oth_fail
        |=> MAN_REJ_O && SEL_LINE_O == $past(s_q.sel)) // RULE6
        else $error("manual switch onto bad line");
    chk_man_lock: assert property (MAN_REQ_I && MAN_LOCK_I |=> SEL_LINE_O != $past(s_q.sel) && LOCK_O) // RULE7
        else $error("lock switch not executed");
    chk_drop_ais: assert property (DROP_I.valid && act_fail |=> DROP_O.data == AIS_BYTE) // RULE8
        else $error("AIS missing on failed line");
    chk_add_pos: assert property (ADD_I.valid && ADD_I.port < N_CHAN
        |=> ADD_O.valid == ($past(s_q.map[ADD_I.port]) != 6'h00)
        && (!ADD_O.valid || sapm_pos2ch(ADD_O.pos) == $past(s_q.map[ADD_I.port]))) // RULE22
        else $error("add position does not match channel");
    chk_cfg_reset: assert property ($rose(RSTN_I) |-> CFG_O == CFG_DEF) // RULE5
        else $error("configuration not at defaults");
    cov_auto_sw: cover property (!SEL_LINE_O ##1 SEL_LINE_O && !LOCK_O);
    cov_wtr_done: cover property (PROT_ST_O == PS_WTR ##1 PROT_ST_O == PS_WORK);
    cov_refused: cover property (MAN_REJ_O);
    cov_lock: cover property (LOCK_O && LINE_FAIL_O);
endmodule

/* File: rtl/sapm_laser.sv */
// Laser shutoff with periodic restart
`timescale 1ns/1ps
module sapm_laser (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic sec_tick_i,
    input wire logic als_en_i,
    input wire logic rx_fail_i,
    input wire logic [8:0] delay_sec_i,
    input wire logic man_start_i,
    output logic laser_on_o
);
    import sapm_pkg::*;
    typedef struct packed {sapm_las_st_t st; logic [8:0] cnt; logic on;} sapm_las_state_t;
    localparam sapm_las_state_t RST = '{LS_ON, 9'h000, 1'b1};
    sapm_las_state_t s_q, s_d;

    // Shutoff, wait, test pulse, recovery
    always_comb
    begin
        s_d = s_q;
        case (s_q.st)
            LS_ON:
            begin
                s_d.on = 1'b1;
                if (als_en_i && rx_fail_i) // RULE9
                begin
                    s_d.st = LS_OFF;
                    s_d.cnt = '0;
                    s_d.on = 1'b0;
                end
            end
            LS_OFF:
            begin
                if (!als_en_i || !rx_fail_i)
                begin
                    s_d.st = LS_ON; // RULE11
                    s_d.on = 1'b1;
                end
                else if (man_start_i || (sec_tick_i && s_q.cnt + 9'h001 >= delay_sec_i)) // RULE10 RULE11
                begin
                    s_d.st = LS_TEST;
                    s_d.cnt = '0;
                    s_d.on = 1'b1;
                end
                else if (sec_tick_i)
                    s_d.cnt = s_q.cnt + 9'h001;
            end
            LS_TEST:
            begin
                if (!als_en_i || !rx_fail_i)
                    s_d.st = LS_ON; // RULE11
                else if (sec_tick_i && s_q.cnt + 9'h001 >= TEST_SEC)
                begin
                    s_d.st = LS_OFF;
                    s_d.cnt = '0;
                    s_d.on = 1'b0;
                end
                else if (sec_tick_i)
                    s_d.cnt = s_q.cnt + 9'h001;
            end
            default: s_d = RST;
        endcase
    end

    // State register
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            s_q <= RST;
        else
            s_q <= s_d;
    end

    assign laser_on_o = s_q.on;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    chk_als_shut: assert property (s_q.st == LS_ON && als_en_i && rx_fail_i |=> !laser_on_o) // RULE9
        else $error("laser stays on after receive loss");
    chk_als_wait: assert property (s_q.st == LS_OFF && als_en_i && rx_fail_i && !man_start_i && !sec_tick_i
        |=> !laser_on_o) // RULE10
        else $error("laser on before restart delay");
    cov_als_test: cover property (s_q.st == LS_OFF ##1 s_q.st == LS_TEST);
endmodule

/* File: rtl/sapm_pkg.sv */
// Shared constants, types and helpers of the aggregate control block
package sapm_pkg;
    localparam logic [31:0] CLK_HZ = 32'h0BEB_C200; // 200 MHz
    localparam logic [31:0] SEC_TIME = 32'h0000_0001; // One second
    localparam logic [31:0] SEC_CYC_DEF = CLK_HZ * SEC_TIME;
    localparam int SEC_W = 28;
    localparam logic [9:0] Q15_LAST = 10'h383; // 900 s per quarter
    localparam logic [1:0] Q_LAST = 2'h3; // Four quarters per hour
    localparam logic [4:0] H_LAST = 5'h17; // 24 hours per day
    localparam logic [5:0] SEC_PER_MIN = 6'h3C;
    localparam logic [8:0] DLY_MIN = 9'h03C; // 60 s
    localparam logic [8:0] DLY_MAX = 9'h12C; // 300 s
    localparam logic [8:0] TEST_SEC = 9'h002;
    localparam logic [5:0] N_CHAN = 6'h3F; // 63 channels and ports
    localparam int N_PAR = 32;
    localparam logic [6:0] H15_N = 7'h60; // 96 quarters
    localparam logic [6:0] HH_N = 7'h18; // 24 hours
    localparam logic [6:0] HD_N = 7'h07; // 7 days
    localparam logic [7:0] AIS_BYTE = 8'hFF;
    localparam logic [5:0] K_N = 6'h03;
    localparam logic [5:0] L_N = 6'h07;
    localparam logic [5:0] KL_N = 6'h15; // 21 channels per TU12 step

    typedef enum logic [1:0] {PS_WORK = 2'h0, PS_PROT = 2'h1, PS_WTR = 2'h3} sapm_prot_st_t;
    typedef enum logic [1:0] {LS_ON = 2'h0, LS_OFF = 2'h1, LS_TEST = 2'h3} sapm_las_st_t;
    typedef struct packed {logic los; logic lof; logic ais;} sapm_line_t;
    typedef struct packed {
        logic revert;
        logic [3:0] wtr_min;
        logic als_en;
        logic [8:0] delay_sec;
        logic [3:0] thr_mant;
        logic [3:0] thr_exp;
    } sapm_cfg_t;
    typedef struct packed {logic [1:0] k; logic [2:0] l; logic [1:0] m;} sapm_pos_t;
    typedef struct packed {logic valid; logic [5:0] port; logic [7:0] data;} sapm_trib_t;
    typedef struct packed {logic valid; sapm_pos_t pos; logic [7:0] data;} sapm_agg_t;

    // Non-revertive, zero wait, laser shutoff off, 300 s, 3e-5
    localparam sapm_cfg_t CFG_DEF = '{1'b0, 4'h0, 1'b0, DLY_MAX, 4'h3, 4'h5}; // RULE5 RULE12

    // Channel number to TUG3/TUG2/TU12 position
    function automatic sapm_pos_t sapm_ch2pos(input logic [5:0] ch);
        logic [5:0] n;
        sapm_pos_t p;
        n = ch - 6'h01;
        p.k = 2'(n % K_N + 6'h01); // RULE21
        p.l = 3'((n / K_N) % L_N + 6'h01);
        p.m = 2'(n / KL_N + 6'h01);
        return p;
    endfunction

    // Position back to channel number
    function automatic logic [5:0] sapm_pos2ch(input sapm_pos_t p);
        return (6'(p.m) - 6'h01) * KL_N + (6'(p.l) - 6'h01) * K_N + 6'(p.k); // RULE21
    endfunction

    // Default threshold; par = layer*8 + end*4 + kind, iv 0..2
    function automatic logic [31:0] sapm_thr_def(input int par, input int iv);
        logic [2:0][31:0] v;
        v = '0;
        case (par % 4)
            0:
            begin
                case (par / 8)
                    0: v = {32'h0002_0D00, 32'h0000_15E0, 32'h0000_0578}; // RULE16
                    1: v = {32'h0001_FB62, 32'h0000_1524, 32'h0000_0549}; // RULE17
                    2: v = {32'h0000_8A48, 32'h0000_05C3, 32'h0000_0171}; // RULE18
                    default: v = {32'h0000_9B85, 32'h0000_067B, 32'h0000_019F}; // RULE19
                endcase
            end
            1: v = {32'h0000_4380, 32'h0000_02D0, 32'h0000_00B4}; // RULE20
            2: v = {32'h0000_10E0, 32'h0000_00B4, 32'h0000_002D}; // RULE20
            default: v = {32'h0000_06C0, 32'h0000_0048, 32'h0000_0012}; // RULE20
        endcase
        return v[iv];
    endfunction
endpackage

/* File: rtl/sapm_pm.sv */
// One performance counter with three intervals, history and alarms
`timescale 1ns/1ps
module sapm_pm #(
    parameter logic [31:0] DEF15 = 32'h0000_0000,
    parameter logic [31:0] DEF1H = 32'h0000_0000,
    parameter logic [31:0] DEF1D = 32'h0000_0000
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic inc_i,
    input wire logic [2:0] end_i,
    input wire logic thr_we_i,
    input wire logic [1:0] thr_iv_i,
    input wire logic [31:0] thr_val_i,
    input wire logic [1:0] rd_iv_i,
    input wire logic [6:0] rd_idx_i,
    output logic [2:0] tca_o,
    output logic [31:0] rd_data_o
);
    import sapm_pkg::*;
    typedef struct packed {
        logic [2:0][31:0] cnt;
        logic [2:0][31:0] thr;
        logic [2:0] threshold_crossing_alarm;
        logic [95:0][31:0] h15;
        logic [23:0][31:0] hh;
        logic [6:0][31:0] hd;
        logic [2:0][6:0] ptr;
        logic [31:0] rd;
    } sapm_pm_state_t;
    localparam sapm_pm_state_t RST = '{thr: {DEF1D, DEF1H, DEF15}, default: '0};
    localparam logic [2:0][6:0] DEPTH = {HD_N, HH_N, H15_N};
    sapm_pm_state_t s_q, s_d;

    // Counting, interval close, thresholds and readback
    always_comb
    begin
        logic [6:0] pos;
        logic [31:0] hv;
        pos = '0;
        hv = '0;
        s_d = s_q;
        for (int i = 0; i < 3; i++)
        begin
            if (end_i[i])
            begin
                s_d.cnt[i] = {31'h0000_0000, inc_i}; // RULE13 RULE14
                s_d.threshold_crossing_alarm[i] = 1'b0;
                s_d.ptr[i] = (s_q.ptr[i] == DEPTH[i] - 7'h01) ? 7'h00 : s_q.ptr[i] + 7'h01;
            end
            else
                s_d.cnt[i] = s_q.cnt[i] + {31'h0000_0000, inc_i}; // RULE13
            if (s_d.cnt[i] > s_q.thr[i])
                s_d.threshold_crossing_alarm[i] = 1'b1; // RULE15
        end
        if (end_i[0])
            s_d.h15[s_q.ptr[0]] = s_q.cnt[0]; // RULE14
        if (end_i[1])
            s_d.hh[s_q.ptr[1][4:0]] = s_q.cnt[1];
        if (end_i[2])
            s_d.hd[s_q.ptr[2][2:0]] = s_q.cnt[2];
        if (thr_we_i && thr_iv_i != 2'h3)
            s_d.thr[thr_iv_i] = thr_val_i; // RULE15
        if (rd_iv_i == 2'h3)
            s_d.rd = (rd_idx_i[1:0] == 2'h3) ? 32'h0000_0000 : s_q.cnt[rd_idx_i[1:0]];
        else if (rd_idx_i >= DEPTH[rd_iv_i])
            s_d.rd = 32'h0000_0000;
        else
        begin
            // Index 0 is the newest closed interval
            pos = s_q.ptr[rd_iv_i] - 7'h01 - rd_idx_i;
            if (s_q.ptr[rd_iv_i] <= rd_idx_i)
                pos = pos + DEPTH[rd_iv_i];
            case (rd_iv_i)
                2'h0: hv = s_q.h15[pos];
                2'h1: hv = s_q.hh[pos[4:0]];
                default: hv = s_q.hd[pos[2:0]];
            endcase
            s_d.rd = hv;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            s_q <= RST;
        else
            s_q <= s_d;
    end

    assign tca_o = s_q.threshold_crossing_alarm;
    assign rd_data_o = s_q.rd;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    chk_tca_raise: assert property (!end_i[0] && s_q.cnt[0] + {31'h0, inc_i} > s_q.thr[0] |=> tca_o[0]) // RULE15
        else $error("threshold crossing not flagged");
    chk_hist_store: assert property (end_i[0] |=> s_q.h15[$past(s_q.ptr[0])] == $past(s_q.cnt[0])) // RULE14
        else $error("quarter count not stored in history");
endmodule

/* File: tb/sapm_aggr_ctl_tb.sv */
// Self-checking bench of the aggregate control block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t bad value", $time); end end
module sapm_aggr_ctl_tb;
    import sapm_pkg::*;
    logic clk = 0, rstn = 0, cfg_we = 0, man = 0, lock = 0, lst = 0, thr_we = 0, map_we = 0;
    logic sel, rej, lck, fail, las;
    logic [1:0] cut = 0, rd_iv = 0;
    logic [6:0] rd_idx = 0;
    logic [5:0] mp = 0, mc = 0;
    logic [31:0] evt = 0, thr = 0, rdd;
    logic [95:0] threshold_crossing_alarm;
    int num_errors = 0, compares = 0;
    sapm_line_t [1:0] line;
    sapm_cfg_t cfg = CFG_DEF, cfg_o;
    sapm_prot_st_t st;
    sapm_trib_t add = '0, drop_o;
    sapm_agg_t drop = '0, add_o;
    sapm_far sapm_far_i (.cut_i(cut), .line_o(line));
    sapm_aggr_ctl #(.SEC_CYC(32'h0000_0004)) sapm_aggr_ctl_i (.CLK_I(clk), .RSTN_I(rstn), .LINE_I(line),
        .CFG_WE_I(cfg_we), .CFG_I(cfg), .MAN_REQ_I(man), .MAN_LOCK_I(lock), .LASER_START_I(lst),
        .PM_EVT_I(evt), .THR_WE_I(thr_we), .THR_PAR_I(5'h00), .THR_IV_I(2'h0), .THR_VAL_I(thr),
        .PM_RD_PAR_I(5'h00), .PM_RD_IV_I(rd_iv), .PM_RD_IDX_I(rd_idx), .MAP_WE_I(map_we),
        .MAP_PORT_I(mp), .MAP_CHAN_I(mc), .ADD_I(add), .DROP_I(drop), .CFG_O(cfg_o), .SEL_LINE_O(sel),
        .PROT_ST_O(st), .LOCK_O(lck), .MAN_REJ_O(rej), .LINE_FAIL_O(fail), .LASER_ON_O(las),
        .TCA_O(threshold_crossing_alarm), .PM_RD_DATA_O(rdd), .ADD_O(add_o), .DROP_O(drop_o));
    // Clock
    always #2.5 clk = ~clk;
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task report_and_stop;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Bounded wait on the selected line (w 0) or the laser (w 1)
    task wait_for(input int w, input logic v, input int n);
        for (int i = 0; i < n && (w ? las : sel) !== v; i++)
            step(1);
        if ((w ? las : sel) !== v)
        begin
            num_errors++;
            report_and_stop;
        end
    endtask
    task t_auto;
        `CHK(cfg_o, sapm_cfg_t'({1'b0, 4'h0, 1'b0, 9'h12C, 8'h35}))
        `CHK({sel, las}, 2'b01)
        cut = 2'b01;
        step(1);
        `CHK({sel, st}, {1'b1, PS_PROT})
        cut = 2'b00;
        step(20);
        `CHK(sel, 1'b1)
    endtask
    task t_manual;
        cut = 2'b01;
        man = 1;
        step(1);
        man = 0;
        `CHK({rej, sel}, 2'b11)
        man = 1;
        lock = 1;
        step(1);
        {man, lock} = 0;
        `CHK({sel, lck}, 2'b01)
        drop = '{1'b1, '{2'h1, 3'h1, 2'h1}, 8'h5A};
        step(4);
        `CHK({sel, fail, drop_o.data}, {2'b01, 8'hFF})
        cut = 2'b00;
        man = 1;
        step(1);
        man = 0;
        `CHK({sel, lck}, 2'b10)
    endtask
    task t_revert;
        cfg = '{1'b1, 4'h1, 1'b0, 9'h12C, 4'h3, 4'h5};
        cfg_we = 1;
        step(1);
        cfg_we = 0;
        step(100);
        cut = 2'b01;
        step(2);
        cut = 2'b00;
        step(200);
        `CHK(sel, 1'b1)
        wait_for(0, 1'b0, 100);
        `CHK(st, PS_WORK)
    endtask
    task t_laser;
        cfg = '{1'b0, 4'h0, 1'b1, 9'h010, 4'h3, 4'h5};
        cfg_we = 1;
        cut = 2'b11;
        step(1);
        cfg_we = 0;
        step(2);
        `CHK(cfg_o.delay_sec, 9'h03C)
        `CHK(las, 1'b0)
        lst = 1;
        step(1);
        lst = 0;
        step(1);
        `CHK(las, 1'b1)
        wait_for(1, 1'b0, 20);
        step(200);
        `CHK(las, 1'b0)
        wait_for(1, 1'b1, 60);
        cut = 2'b00;
        step(30);
        `CHK(las, 1'b1)
    endtask
    task t_map;
        {mp, mc, map_we} = {6'h03, 6'h05, 1'b1};
        step(1);
        map_we = 0;
        add = '{1'b1, 6'h03, 8'hA5};
        drop = '{1'b1, '{2'h2, 3'h2, 2'h1}, 8'h3C};
        step(1);
        {add.valid, drop.valid} = 0;
        `CHK(add_o, sapm_agg_t'({1'b1, 2'h2, 3'h2, 2'h1, 8'hA5}))
        `CHK(drop_o, sapm_trib_t'({1'b1, 6'h03, 8'h3C}))
    endtask
    task t_pm;
        evt[3] = 1;
        step(18);
        evt[3] = 0;
        step(2);
        `CHK(threshold_crossing_alarm[9], 1'b0)
        evt[3] = 1;
        step(1);
        {thr, thr_we, evt} = {32'h0000_0001, 1'b1, 32'h0000_0001};
        step(2);
        {thr_we, evt, rd_iv} = {1'b0, 32'h0, 2'h3};
        step(3);
        `CHK({threshold_crossing_alarm[9], threshold_crossing_alarm[0], rdd}, {2'b11, 32'h0000_0002})
        rd_iv = 0;
        step(3700);
        `CHK({threshold_crossing_alarm[0], rdd}, {1'b0, 32'h0000_0002})
    endtask
    initial
    begin
        step(4);
        rstn = 1;
        t_auto;
        t_manual;
        t_revert;
        t_laser;
        t_map;
        t_pm;
        report_and_stop;
    end
endmodule

/* File: tb/sapm_far.sv */
// Far-end model: two fibers as seen by the local receiver
`timescale 1ns/1ps
module sapm_far (
    input wire logic [1:0] cut_i,
    output sapm_pkg::sapm_line_t [1:0] line_o
);
    import sapm_pkg::*;
    // A cut fiber loses signal and frame
    always_comb
    begin
        line_o[0] = '{cut_i[0], cut_i[0], 1'b0};
        line_o[1] = '{cut_i[1], cut_i[1], 1'b0};
    end
endmodule
